// ### core/thermo_scratchpad.sv
// scratchpad, alarm, conversion and nonvolatile sequencing of the thermometer core
`timescale 1ns/1ps
`include "thermo_map.svh"

// What this block does
// - temperature register holds 16-bit sign-extended two's complement centigrade result
// - lowest temperature bits are cleared to zero at 11, 10 and 9-bit resolution
// - resolution bits reset to both ones, selecting 12-bit resolution
// - externally powered: read slots after convert give 0 busy, 1 done
// - temperature reads plus 85 degrees until the first conversion completes
// - alarm limit bytes are 8-bit two's complement, sign in bit 7
// - alarm compare uses temperature bits 11 to 4 as signed byte
// - alarm flag set when above upper or below lower limit
// - alarm flag recomputed after every conversion, clearing when condition goes
// - read power supply: parasite device drives slot low, external leaves high
// - identity code: family low byte, 48-bit serial, CRC of 56 bits on top
// - scratchpad bytes 0 and 1 show temperature and ignore writes
// - bytes 5 to 7 are reserved, unwritable, and read as all ones
// - byte 8 is read-only CRC over scratchpad bytes 0 to 7
// - write scratchpad takes bytes 2, 3, 4 in order, lsb first
// - read scratchpad sends bytes from byte 0, lsb first
// - upper limit, lower limit, configuration sit at bytes 2, 3, 4
// - copy scratchpad stores limits and configuration into nonvolatile storage
// - power-up loads nonvolatile values into the scratchpad
// - recall reloads nonvolatile values; read slots give 0 busy, 1 done
module thermo_scratchpad #(
  parameter int unsigned CONV_CYCLES = `CONV_CYCLES,
  parameter int unsigned NV_WRITE_CYCLES = `NV_WRITE_CYCLES,
  // arbitrary family code and serial number, not those of any real part
  parameter logic [7:0] FAMILY_CODE = 8'h5A,
  parameter logic [47:0] SERIAL_NUMBER = 48'h0000_0000_0001
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // decoded function commands and written bytes
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic wr_byte_valid_in,
  input wire logic [7:0] wr_byte_in,
  input wire logic bus_reset_in,
  // read slots
  input wire logic rd_slot_in,
  output logic rd_bit_out,
  // sensor side
  input wire logic parasite_power_in,
  input wire logic [15:0] sample_in,
  output logic conv_start_out,
  output logic busy_out,
  // identity and alarm
  output logic [63:0] rom_code_out,
  output logic alarm_flag_out,
  output logic [15:0] temperature_out
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // reflected crc, lsb first, x^8+x^5+x^4+1, shared by rom and scratchpad
  function automatic logic [7:0] crc8(input logic [63:0] bits, input int unsigned count);
    logic [7:0] crc;
    logic fb;
    crc = 8'h00;
    for (int i = 0; i < 64; i++) begin
      if (i < count) begin
        fb = crc[0] ^ bits[i];
        crc = crc >> 1;
        if (fb) begin
          crc = crc ^ `CRC_POLY_REFLECTED;
        end
      end
    end
    return crc;
  endfunction

  // clear the bits the chosen resolution leaves undefined so crc and reads are stable
  function automatic logic [15:0] trim_result(input logic [15:0] raw, input logic [1:0] res);
    logic [15:0] out;
    out = raw;
    case (res)
      2'h0: out[2:0] = 3'h0;
      2'h1: out[1:0] = 2'h0;
      2'h2: out[0] = 1'h0;
      default: out = raw;
    endcase
    return out;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  thermo_pkg::seq_state_type state, next_state;
  thermo_pkg::read_mode_type read_mode, next_read_mode;
  logic [31:0] count, next_count;
  logic [15:0] temperature, next_temperature;
  logic [7:0] upper_alarm_limit, next_upper_alarm_limit;
  logic [7:0] lower_alarm_limit, next_lower_alarm_limit;
  logic [1:0] resolution, next_resolution;
  logic alarm_flag, next_alarm_flag;
  logic write_active, next_write_active;
  logic [1:0] write_index, next_write_index;
  logic [6:0] read_index, next_read_index;
  logic [7:0] check_byte, next_check_byte;
  logic next_rd_bit;
  logic next_conv_start;
  logic [63:0] next_rom_code;
  logic [31:0] conv_limit;
  logic [7:0] config_byte;
  logic [63:0] pad_low;
  logic [71:0] pad_image;
  logic nv_write_en;
  logic [1:0] nv_addr;
  logic [7:0] nv_write_data;
  logic [7:0] nv_read_data;

  // ****************************************************************
  // scratchpad image
  // ****************************************************************
  always_comb begin
    config_byte = {`CFG_TOP_BIT, resolution, `CFG_LOW_BITS};
    pad_low = {`RESERVED_BYTE, `RESERVED_BYTE, `RESERVED_BYTE,
               config_byte, lower_alarm_limit, upper_alarm_limit,
               temperature};
    pad_image = {check_byte, pad_low};
    next_check_byte = crc8(pad_low, `PAD_CRC_BITS);
    next_rom_code = {8'h00, SERIAL_NUMBER, FAMILY_CODE};
    next_rom_code[63:56] = crc8(next_rom_code, `ROM_CRC_BITS);
    conv_limit = CONV_CYCLES >> (2'h3 - resolution);
  end

  // ****************************************************************
  // nonvolatile store
  // ****************************************************************
  nv_store u_nv_store (
    .clk_sys_in(clk_sys_in),
    .write_en_in(nv_write_en),
    .addr_in(nv_addr),
    .write_data_in(nv_write_data),
    .read_data_out(nv_read_data)
  );

  always_comb begin
    nv_write_en = (state == thermo_pkg::ST_COPY) && (count < 32'(`PAD_WRITE_BYTES));
    nv_addr = count[1:0];
    case (count[1:0])
      `NV_ADDR_UPPER: nv_write_data = upper_alarm_limit;
      `NV_ADDR_LOWER: nv_write_data = lower_alarm_limit;
      default: nv_write_data = config_byte;
    endcase
  end

  // ****************************************************************
  // sequencer, scratchpad contents and alarm
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_count = count;
    next_temperature = temperature;
    next_upper_alarm_limit = upper_alarm_limit;
    next_lower_alarm_limit = lower_alarm_limit;
    next_resolution = resolution;
    next_alarm_flag = alarm_flag;
    next_conv_start = 1'b0;
    case (state)
      thermo_pkg::ST_IDLE: begin
        if (cmd_valid_in && cmd_code_in == `CMD_CONVERT) begin
          next_state = thermo_pkg::ST_CONVERT;
          next_count = 32'h0;
          next_conv_start = 1'b1;
        end else if (cmd_valid_in && cmd_code_in == `CMD_COPY_PAD) begin
          next_state = thermo_pkg::ST_COPY;
          next_count = 32'h0;
        end else if (cmd_valid_in && cmd_code_in == `CMD_RECALL) begin
          next_state = thermo_pkg::ST_RECALL;
          next_count = 32'h0;
        end else if (write_active && wr_byte_valid_in) begin
          // bytes beyond the third are dropped; bytes 0, 1, 5-7 are never targets
          case (write_index)
            2'h0: next_upper_alarm_limit = wr_byte_in;
            2'h1: next_lower_alarm_limit = wr_byte_in;
            default: next_resolution = wr_byte_in[`CFG_RES_MSB:`CFG_RES_LSB];
          endcase
        end
      end
      thermo_pkg::ST_CONVERT: begin
        next_count = count + 32'h1;
        if (count + 32'h1 >= conv_limit) begin
          next_state = thermo_pkg::ST_IDLE;
          next_temperature = trim_result(sample_in, resolution);
          // signed byte compare of bits 11..4 against both limits
          next_alarm_flag =
            ($signed(sample_in[`TEMP_CMP_MSB:`TEMP_CMP_LSB]) > $signed(upper_alarm_limit)) ||
            ($signed(sample_in[`TEMP_CMP_MSB:`TEMP_CMP_LSB]) < $signed(lower_alarm_limit));
        end
      end
      thermo_pkg::ST_COPY: begin
        next_count = count + 32'h1;
        // parasite parts rely on the master's strong pullup for this whole wait
        if (count + 32'h1 >= NV_WRITE_CYCLES + 32'(`PAD_WRITE_BYTES)) begin
          next_state = thermo_pkg::ST_IDLE;
        end
      end
      default: begin
        // read data lags its address by one cycle, so each step loads the previous byte
        next_count = count + 32'h1;
        case (count[1:0])
          2'h1: next_upper_alarm_limit = nv_read_data;
          2'h2: next_lower_alarm_limit = nv_read_data;
          2'h3: next_resolution = nv_read_data[`CFG_RES_MSB:`CFG_RES_LSB];
          default: next_count = count + 32'h1;
        endcase
        if (count[1:0] == `RECALL_LAST_STEP) begin
          next_state = thermo_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // ****************************************************************
  // command framing and read slot answers
  // ****************************************************************
  always_comb begin
    next_read_mode = read_mode;
    next_write_active = write_active;
    next_write_index = write_index;
    next_read_index = read_index;
    if (bus_reset_in) begin
      next_read_mode = thermo_pkg::RD_RELEASE;
      next_write_active = 1'b0;
    end else if (cmd_valid_in && state == thermo_pkg::ST_IDLE) begin
      next_write_active = (cmd_code_in == `CMD_WRITE_PAD);
      next_write_index = 2'h0;
      next_read_index = 7'h0;
      case (cmd_code_in)
        `CMD_CONVERT: next_read_mode = thermo_pkg::RD_STATUS;
        `CMD_RECALL: next_read_mode = thermo_pkg::RD_STATUS;
        `CMD_READ_POWER: next_read_mode = thermo_pkg::RD_POWER;
        `CMD_READ_PAD: next_read_mode = thermo_pkg::RD_PAD;
        default: next_read_mode = thermo_pkg::RD_RELEASE;
      endcase
    end else begin
      if (write_active && wr_byte_valid_in && state == thermo_pkg::ST_IDLE) begin
        next_write_index = write_index + 2'h1;
        next_write_active = (write_index + 2'h1) != `PAD_WRITE_BYTES;
      end
      if (rd_slot_in && read_mode == thermo_pkg::RD_PAD && read_index != `PAD_BITS) begin
        next_read_index = read_index + 7'h1;
      end
    end
    case (next_read_mode)
      thermo_pkg::RD_STATUS: next_rd_bit = (next_state == thermo_pkg::ST_IDLE);
      thermo_pkg::RD_POWER: next_rd_bit = !parasite_power_in;
      thermo_pkg::RD_PAD: next_rd_bit =
        (next_read_index == `PAD_BITS) ? 1'b1 : pad_image[next_read_index];
      default: next_rd_bit = 1'b1;
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state <= thermo_pkg::ST_RECALL;
      count <= 32'h0;
      temperature <= `TEMP_RESET;
      upper_alarm_limit <= 8'h00;
      lower_alarm_limit <= 8'h00;
      resolution <= `CFG_RES_RESET;
      alarm_flag <= 1'b0;
      read_mode <= thermo_pkg::RD_RELEASE;
      write_active <= 1'b0;
      write_index <= 2'h0;
      read_index <= 7'h0;
      check_byte <= 8'h00;
      rd_bit_out <= 1'b1;
      conv_start_out <= 1'b0;
      rom_code_out <= 64'h0;
    end else begin
      state <= next_state;
      count <= next_count;
      temperature <= next_temperature;
      upper_alarm_limit <= next_upper_alarm_limit;
      lower_alarm_limit <= next_lower_alarm_limit;
      resolution <= next_resolution;
      alarm_flag <= next_alarm_flag;
      read_mode <= next_read_mode;
      write_active <= next_write_active;
      write_index <= next_write_index;
      read_index <= next_read_index;
      check_byte <= next_check_byte;
      rd_bit_out <= next_rd_bit;
      conv_start_out <= next_conv_start;
      rom_code_out <= next_rom_code;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_comb begin
    busy_out = (state != thermo_pkg::ST_IDLE);
    alarm_flag_out = alarm_flag;
    temperature_out = temperature;
  end

endmodule // thermo_scratchpad

// ### include/thermo_map.svh
// offsets, field positions, reset values, command codes and timing counts of the thermometer core
`ifndef THERMO_MAP_SVH
`define THERMO_MAP_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define CLK_FREQ_KHZ 125000
`define CONV_TIME_MS 750
`define NV_WRITE_TIME_MS 10
`define CONV_CYCLES (`CONV_TIME_MS * `CLK_FREQ_KHZ)
`define NV_WRITE_CYCLES (`NV_WRITE_TIME_MS * `CLK_FREQ_KHZ)
`define RECALL_LAST_STEP 2'h3

// ****************************************************************
// function command codes
// ****************************************************************
`define CMD_CONVERT 8'h44
`define CMD_WRITE_PAD 8'h4E
`define CMD_READ_PAD 8'hBE
`define CMD_COPY_PAD 8'h48
`define CMD_RECALL 8'hB8
`define CMD_READ_POWER 8'hB4

// ****************************************************************
// scratchpad byte offsets
// ****************************************************************
`define PAD_TEMP_LOW 4'h0
`define PAD_TEMP_HIGH 4'h1
`define PAD_UPPER_LIMIT 4'h2
`define PAD_LOWER_LIMIT 4'h3
`define PAD_CONFIG 4'h4
`define PAD_RESERVED_FIVE 4'h5
`define PAD_RESERVED_SIX 4'h6
`define PAD_RESERVED_SEVEN 4'h7
`define PAD_CHECK 4'h8
`define PAD_BITS 7'h48
`define PAD_WRITE_BYTES 2'h3

// ****************************************************************
// fields and reset values
// ****************************************************************
`define TEMP_RESET 16'h0550
`define TEMP_CMP_MSB 11
`define TEMP_CMP_LSB 4
`define CFG_RES_LSB 5
`define CFG_RES_MSB 6
`define CFG_RES_RESET 2'h3
`define CFG_TOP_BIT 1'h0
`define CFG_LOW_BITS 5'h1F
`define RESERVED_BYTE 8'hFF
`define CRC_POLY_REFLECTED 8'h8C
`define ROM_CRC_BITS 56
`define PAD_CRC_BITS 64

// ****************************************************************
// nonvolatile store addresses and factory contents
// ****************************************************************
`define NV_ADDR_UPPER 2'h0
`define NV_ADDR_LOWER 2'h1
`define NV_ADDR_CONFIG 2'h2
`define NV_FACTORY_UPPER 8'h4B
`define NV_FACTORY_LOWER 8'h46
`define NV_FACTORY_CONFIG 8'h7F

`endif

// ### include/thermo_pkg.sv
// types shared by the thermometer core files
package thermo_pkg;

  // ****************************************************************
  // sequencer states, gray coded along idle-convert-copy-recall
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CONVERT = 2'h1,
    ST_COPY = 2'h3,
    ST_RECALL = 2'h2
  } seq_state_type;

  // ****************************************************************
  // what the master's read slots are answered with
  // ****************************************************************
  typedef enum logic [1:0] {
    RD_RELEASE = 2'h0,
    RD_STATUS = 2'h1,
    RD_POWER = 2'h2,
    RD_PAD = 2'h3
  } read_mode_type;

endpackage

// ### core/nv_store.sv
// nonvolatile byte store for the alarm limits and configuration byte
`timescale 1ns/1ps
`include "thermo_map.svh"

module nv_store (
  // clock
  input wire logic clk_sys_in,
  // access port
  input wire logic write_en_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] write_data_in,
  output logic [7:0] read_data_out
);

  // contents survive reset on purpose; factory values stand in for a blank part
  // given at declaration so no second process writes the cells; order is upper, lower, config
  logic [7:0] cells [0:3] = '{`NV_FACTORY_UPPER, `NV_FACTORY_LOWER, `NV_FACTORY_CONFIG,
    `RESERVED_BYTE};
  logic [7:0] next_read_data;

  always_comb begin
    next_read_data = cells[addr_in];
  end

  always_ff @(posedge clk_sys_in) begin
    if (write_en_in) begin
      cells[addr_in] <= write_data_in;
    end
    read_data_out <= next_read_data;
  end

endmodule // nv_store

// ### tb/thermo_monitor.sv
// port-level assertion checker for the thermometer core
`timescale 1ns/1ps
module thermo_monitor (
  // watched ports
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic parasite_power_in,
  input wire logic [15:0] sample_in,
  input wire logic rd_bit_out,
  input wire logic conv_start_out,
  input wire logic busy_out,
  input wire logic alarm_flag_out,
  input wire logic [15:0] temperature_out
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  logic take;
  // a command only counts when the sequencer is idle
  assign take = cmd_valid_in && !busy_out;
  chk_conv_start: assert property (take && cmd_code_in == 8'h44 |=> busy_out && conv_start_out)
    else $error("convert did not start");
  chk_start_pulse: assert property (conv_start_out |=> !conv_start_out)
    else $error("start pulse longer than one cycle");
  chk_busy_ignore: assert property (busy_out && cmd_valid_in |=> !conv_start_out)
    else $error("command taken while busy");
  chk_conv_status: assert property (take && cmd_code_in == 8'h44 |=> (busy_out && !rd_bit_out)[*6])
    else $error("status not low during conversion");
  chk_status_done: assert property ($fell(busy_out) && !$past(rd_bit_out) |-> ##[0:1] rd_bit_out)
    else $error("status not high after completion");
  chk_recall_len: assert property (take && cmd_code_in == 8'hB8 |=> busy_out[*4] ##1 !busy_out)
    else $error("recall length wrong");
  chk_power_bit: assert property (take && cmd_code_in == 8'hB4 |=> rd_bit_out == !$past(parasite_power_in))
    else $error("power report wrong");
  chk_temp_when: assert property ($changed(temperature_out) || $changed(alarm_flag_out) |-> $past(busy_out))
    else $error("result changed outside a conversion");
  chk_temp_value: assert property ($changed(temperature_out) |-> temperature_out[15:3] == $past(sample_in[15:3]))
    else $error("temperature does not match sample");
  chk_reset_state: assert property ($rose(rst_n_in) |-> temperature_out == 16'h0550 && !alarm_flag_out ##[1:2] busy_out)
    else $error("reset state wrong");
  cover property (take && cmd_code_in == 8'h48);
  cover property ($rose(alarm_flag_out));
  cover property ($fell(alarm_flag_out));
endmodule // thermo_monitor

// ### tb/master_model.sv
// behavioural bus master: issues commands, writes bytes and clocks read slots
`timescale 1ns/1ps
module master_model (
  // clock
  input wire logic clk_sys_in,
  // device side
  input wire logic rd_bit_in,
  output logic cmd_valid_out,
  output logic [7:0] cmd_code_out,
  output logic wr_byte_valid_out,
  output logic [7:0] wr_byte_out,
  output logic bus_reset_out,
  output logic rd_slot_out,
  // bytes gathered from read slots
  output logic got_valid_out,
  output logic [7:0] got_byte_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_code_out = 8'h00;
    wr_byte_valid_out = 1'b0;
    wr_byte_out = 8'h00;
    bus_reset_out = 1'b0;
    rd_slot_out = 1'b0;
    got_valid_out = 1'b0;
    got_byte_out = 8'h00;
  end
  // ****************************************************************
  // transfers; released fields show the inverse so stale data never passes
  // ****************************************************************
  task automatic send_cmd(input logic [7:0] c);
    @(posedge clk_sys_in);
    cmd_valid_out <= 1'b1;
    cmd_code_out <= c;
    @(posedge clk_sys_in);
    cmd_valid_out <= 1'b0;
    cmd_code_out <= ~c;
  endtask
  task automatic send_byte(input logic [7:0] d);
    @(posedge clk_sys_in);
    wr_byte_valid_out <= 1'b1;
    wr_byte_out <= d;
    @(posedge clk_sys_in);
    wr_byte_valid_out <= 1'b0;
    wr_byte_out <= ~d;
  endtask
  task automatic pulse_reset;
    @(posedge clk_sys_in);
    bus_reset_out <= 1'b1;
    @(posedge clk_sys_in);
    bus_reset_out <= 1'b0;
  endtask
  task automatic read_bit(output logic b);
    @(posedge clk_sys_in);
    b = rd_bit_in;
    rd_slot_out <= 1'b1;
    @(posedge clk_sys_in);
    rd_slot_out <= 1'b0;
  endtask
  task automatic read_byte;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      read_bit(v[i]);
    end
    got_byte_out <= v;
    got_valid_out <= 1'b1;
    @(posedge clk_sys_in);
    got_valid_out <= 1'b0;
  endtask
endmodule // master_model

// ### tb/tb.sv
// self-checking testbench of the thermometer core
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module tb;
  // arbitrary identity values
  localparam logic [7:0] FAM = 8'h3C;
  localparam logic [47:0] SER = 48'h0123_4567_89AB;
  logic clk_sys_in, rst_n_in, parasite_power_in;
  logic [15:0] sample_in, temperature, temp;
  logic cmd_valid, wr_valid, bus_reset, rd_slot, rd_bit, conv_start, busy, alarm, got_valid, b;
  logic [7:0] cmd_code, wr_byte, got_byte, exp_b, up, lo, cfg, nvu, nvl, nvc;
  logic [63:0] rom_code;
  logic [31:0] r;
  logic [1:0] res;
  logic [7:0] exp_q[$];
  int error_cnt, n_checks;
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  thermo_scratchpad #(.CONV_CYCLES(64), .NV_WRITE_CYCLES(16), .FAMILY_CODE(FAM),
    .SERIAL_NUMBER(SER)) dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .wr_byte_valid_in(wr_valid),
    .wr_byte_in(wr_byte), .bus_reset_in(bus_reset), .rd_slot_in(rd_slot), .rd_bit_out(rd_bit),
    .parasite_power_in(parasite_power_in), .sample_in(sample_in), .conv_start_out(conv_start),
    .busy_out(busy), .rom_code_out(rom_code), .alarm_flag_out(alarm),
    .temperature_out(temperature));
  master_model mm (.clk_sys_in(clk_sys_in), .rd_bit_in(rd_bit), .cmd_valid_out(cmd_valid),
    .cmd_code_out(cmd_code), .wr_byte_valid_out(wr_valid), .wr_byte_out(wr_byte),
    .bus_reset_out(bus_reset), .rd_slot_out(rd_slot), .got_valid_out(got_valid),
    .got_byte_out(got_byte));
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] crc8(input logic [63:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    end
    return c;
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_idle(input int lim);
    int i;
    i = 0;
    do begin
      @(posedge clk_sys_in);
      i++;
    end while (busy !== 1'b0 && i < lim);
    if (i >= lim) begin
      error_cnt++;
      $display("ERROR %0t: device stayed busy", $time);
      end_sim();
    end
  endtask
  task automatic reset_dut;
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
    `CHK(temperature, 16'h0550)
    rst_n_in <= 1'b1;
    up = nvu;
    lo = nvl;
    cfg = nvc;
    temp = 16'h0550;
    repeat (5) @(posedge clk_sys_in);
    wait_idle(12);
    `CHK(alarm, 1'b0)
  endtask
  task automatic read_pad;
    logic [63:0] p;
    p = {24'hFFFFFF, cfg, lo, up, temp};
    mm.send_cmd(8'hBE);
    for (int i = 0; i < 8; i++) begin
      exp_q.push_back(p[8*i +: 8]);
    end
    exp_q.push_back(crc8(p, 64));
    for (int i = 0; i < 9; i++) begin
      mm.read_byte();
    end
  endtask
  task automatic write_pad(input logic [7:0] u, input logic [7:0] l, input logic [7:0] c);
    mm.send_cmd(8'h4E);
    mm.send_byte(u);
    mm.send_byte(l);
    mm.send_byte(c);
    mm.send_byte(~u); // a fourth byte has nowhere to go
    up = u;
    lo = l;
    cfg = {1'b0, c[6:5], 5'h1F};
  endtask
  // ****************************************************************
  // result watcher and main sequence
  // ****************************************************************
  always @(posedge clk_sys_in) begin
    if (got_valid === 1'b1) begin
      exp_b = exp_q.pop_front();
      `CHK(got_byte, exp_b)
    end
  end
  initial begin
    rst_n_in = 1'b0;
    parasite_power_in = 1'b0;
    sample_in = 16'h0000;
    error_cnt = 0;
    n_checks = 0;
    void'($urandom(2));
    nvu = 8'h4B;
    nvl = 8'h46;
    nvc = 8'h7F;
    reset_dut();
    `CHK(rom_code, {crc8({8'h00, SER, FAM}, 56), SER, FAM})
    read_pad();
    for (int i = 0; i < 8; i++) begin
      res = i[1:0];
      r = $urandom;
      // widest limits last, so a set alarm has to clear
      if (i == 7) r[15:0] = 16'h807F;
      write_pad(r[7:0], r[15:8], {r[23], res, r[28:24]});
      sample_in <= {{5{r[31]}}, r[31:21]};
      mm.send_cmd(8'h44);
      mm.send_cmd(8'hB4);
      mm.read_bit(b);
      `CHK(b, 1'b0)
      wait_idle(80);
      mm.read_bit(b);
      `CHK(b, 1'b1)
      temp = sample_in & (16'hFFFF << (2'h3 - res));
      `CHK(alarm, ($signed(sample_in[11:4]) > $signed(up)) || ($signed(sample_in[11:4]) < $signed(lo)))
      read_pad();
    end
    for (int p = 0; p < 2; p++) begin
      parasite_power_in <= p[0];
      mm.send_cmd(8'hB4);
      mm.read_bit(b);
      `CHK(b, ~p[0])
    end
    // copy in parasite mode: the master keeps the bus quiet for the whole write
    write_pad(8'h19, 8'hE7, 8'h60);
    mm.send_cmd(8'h48);
    wait_idle(40);
    parasite_power_in <= 1'b0;
    nvu = up;
    nvl = lo;
    nvc = cfg;
    write_pad(8'hA5, 8'h5A, 8'h1F);
    mm.send_cmd(8'h4E);
    mm.pulse_reset();
    mm.send_byte(8'h00); // framing already ended by the bus reset
    read_pad();
    mm.send_cmd(8'hB8);
    mm.read_bit(b);
    `CHK(b, 1'b0)
    wait_idle(12);
    mm.read_bit(b);
    `CHK(b, 1'b1)
    up = nvu;
    lo = nvl;
    cfg = nvc;
    read_pad();
    write_pad(8'h01, 8'h02, 8'h00);
    reset_dut();
    read_pad();
    repeat (2) @(posedge clk_sys_in);
    `CHK(exp_q.size(), 0)
    end_sim();
  end
endmodule // tb
bind thermo_scratchpad thermo_monitor mon (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in), .parasite_power_in(parasite_power_in),
  .sample_in(sample_in), .rd_bit_out(rd_bit_out), .conv_start_out(conv_start_out),
  .busy_out(busy_out), .alarm_flag_out(alarm_flag_out), .temperature_out(temperature_out));
